// ### core/led_current_i2c_slave.sv
module led_current_i2c_slave
  import led_drv_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        scl,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        overvoltage_monitor,
  output logic [7:0]       backlight_current_level,
  output logic [7:0]       flash_current_level,
  output logic             fourth_led_connect,
  output logic [10:0]      backlight_mirror_gain,
  output logic [10:0]      flash_mirror_gain,
  output logic             pump_enable,
  output logic             pump_charge,
  output logic             pump_transfer
);
  import led_drv_pkg::*;

  // ---------------- link domain, clocked by scl ----------------
  // reset into the scl domain, synchronised (release on scl edges)
  logic lrst_meta_ff;
  logic lrst_n_ff;
  always_ff @(posedge scl) begin
    lrst_meta_ff <= rstn;
    lrst_n_ff    <= lrst_meta_ff;
  end

  // start / stop detection: sda edges while scl high
  logic start_tog_ff;
  logic stop_tog_ff;
  always_ff @(negedge sda_in or negedge rstn) begin
    if (!rstn) start_tog_ff <= 1'b0;
    else if (scl) start_tog_ff <= ~start_tog_ff;
  end
  always_ff @(posedge sda_in or negedge rstn) begin
    if (!rstn) stop_tog_ff <= 1'b0;
    else if (scl) stop_tog_ff <= ~stop_tog_ff;
  end
  logic start_seen_ff;
  logic stop_seen_ff;
  wire  new_start  = start_tog_ff != start_seen_ff;
  wire  frame_stop = stop_tog_ff != stop_seen_ff;

  logic [2:0]  bitcnt_ff;
  logic [1:0]  byteidx_ff;
  logic [7:0]  shift_ff;
  logic [7:0]  sel_ff;
  logic        active_ff;
  logic        ack_due_ff;
  logic [7:0]  wr_data_ff;
  logic        wr_is_bk_ff;
  logic        wr_tog_ff;

  wire [7:0] rx_byte   = {shift_ff[6:0], sda_in};
  wire       last_bit  = bitcnt_ff == 3'h7;
  wire       addr_ok   = rx_byte == {SLAVE_ADDR, 1'b0};
  wire       sel_bk    = sel_ff == SEL_BACKLIGHT;
  wire       sel_fl    = sel_ff == SEL_FLASH;

  always_ff @(posedge scl) begin
    if (!lrst_n_ff || new_start || frame_stop) begin
      start_seen_ff <= start_tog_ff;
      stop_seen_ff  <= stop_tog_ff;
      active_ff     <= new_start;
      bitcnt_ff     <= 3'h0;
      byteidx_ff    <= BYTE_ADDR;
      shift_ff      <= 8'h00;
      if (!lrst_n_ff) begin
        sel_ff      <= 8'h00;
        wr_data_ff  <= 8'h00;
        wr_is_bk_ff <= 1'b0;
        wr_tog_ff   <= 1'b0;
      end
      if (new_start) begin
        shift_ff  <= {7'h00, sda_in};
        bitcnt_ff <= 3'h1;
      end
    end else if (ack_due_ff) begin
      // acknowledge clock carries no data
      if (byteidx_ff == BYTE_DONE) active_ff <= 1'b0;
    end else if (active_ff && byteidx_ff != BYTE_DONE) begin
      shift_ff  <= rx_byte;
      bitcnt_ff <= bitcnt_ff + 3'h1;
      if (last_bit) begin
        case (byteidx_ff)
          BYTE_ADDR: begin
            active_ff  <= addr_ok;
            byteidx_ff <= BYTE_SEL;
          end
          BYTE_SEL: begin
            sel_ff     <= rx_byte;
            byteidx_ff <= BYTE_VAL;
          end
          default: begin
            byteidx_ff <= BYTE_DONE;
            if (sel_bk || sel_fl) begin
              wr_data_ff  <= rx_byte;
              wr_is_bk_ff <= sel_bk;
              wr_tog_ff   <= ~wr_tog_ff;
            end
          end
        endcase
      end
    end
  end

  // acknowledge slot: driven from the falling edge after each taken byte
  always_ff @(negedge scl) begin
    if (!lrst_n_ff) begin
      ack_due_ff <= 1'b0;
      sda_oe     <= 1'b0;
    end else begin
      ack_due_ff <= active_ff && bitcnt_ff == 3'h0 && byteidx_ff != BYTE_ADDR && !ack_due_ff;
      sda_oe     <= active_ff && bitcnt_ff == 3'h0 && byteidx_ff != BYTE_ADDR && !ack_due_ff;
    end
  end
  assign sda_out = 1'b0;

  // ---------------- system domain ----------------
  logic wr_sync;
  logic ov_sync;
  bit_sync u_wr_sync (.mclk(mclk), .rstn(rstn), .din(wr_tog_ff), .dout(wr_sync));
  bit_sync u_ov_sync (.mclk(mclk), .rstn(rstn), .din(overvoltage_monitor), .dout(ov_sync));

  logic       wr_seen_ff;
  wire        wr_event = wr_sync != wr_seen_ff;
  wire [7:0]  nxt_bk   = {wr_data_ff[BK_LED4_BIT], 2'b00, wr_data_ff[BK_CODE_MSB:0]};
  wire [7:0]  nxt_fl   = {1'b0, wr_data_ff[FL_CODE_MSB:0]};
  wire [10:0] nxt_bk_gain = 11'(MIRROR_UNIT_W * {6'h00, backlight_current_level[BK_CODE_MSB:0]});
  wire [10:0] nxt_fl_gain = 11'(MIRROR_UNIT_W * {4'h0, flash_current_level[FL_CODE_MSB:0]});
  wire        nxt_pump_en = (backlight_current_level[BK_CODE_MSB:0] != 5'h00) ||
                            (flash_current_level[FL_CODE_MSB:0] != 7'h00);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wr_seen_ff              <= 1'b0;
      backlight_current_level <= BK_RESET;
      flash_current_level     <= FL_RESET;
      fourth_led_connect      <= 1'b0;
      backlight_mirror_gain   <= 11'h000;
      flash_mirror_gain       <= 11'h000;
      pump_enable             <= 1'b0;
    end else begin
      wr_seen_ff            <= wr_sync;
      if (wr_event && wr_is_bk_ff) begin
        backlight_current_level <= nxt_bk;
        fourth_led_connect      <= wr_data_ff[BK_LED4_BIT];
      end
      if (wr_event && !wr_is_bk_ff) begin
        flash_current_level <= nxt_fl;
      end
      backlight_mirror_gain <= nxt_bk_gain;
      flash_mirror_gain     <= nxt_fl_gain;
      pump_enable           <= nxt_pump_en;
    end
  end

  // two-phase pump sequencer
  pump_phase_t phase_ff;
  logic [7:0]  phcnt_ff;
  wire         run      = pump_enable && !ov_sync;
  wire         ph_end   = phcnt_ff == 8'(PUMP_HALF_CYC - 1);
  always_ff @(posedge mclk) begin
    if (!rstn || !run) begin
      phase_ff      <= PH_CHARGE;
      phcnt_ff      <= 8'h00;
      pump_charge   <= 1'b0;
      pump_transfer <= 1'b0;
    end else begin
      phcnt_ff <= ph_end ? 8'h00 : phcnt_ff + 8'h01;
      case (phase_ff)
        PH_CHARGE: begin
          if (ph_end) phase_ff <= PH_TRANSFER;
        end
        default: begin
          if (ph_end) phase_ff <= PH_CHARGE;
        end
      endcase
      pump_charge   <= phase_ff == PH_CHARGE;
      pump_transfer <= phase_ff == PH_TRANSFER;
    end
  end
endmodule // led_current_i2c_slave

// ### core/led_drv_pkg.sv
package led_drv_pkg;
  localparam logic [6:0] SLAVE_ADDR      = 7'h39;
  localparam logic [7:0] SEL_BACKLIGHT   = 8'h01;
  localparam logic [7:0] SEL_FLASH       = 8'h02;
  localparam int         BK_CODE_MSB     = 4;
  localparam int         FL_CODE_MSB     = 6;
  localparam int         BK_LED4_BIT     = 7;
  localparam logic [7:0] BK_RESET        = 8'h00;
  localparam logic [7:0] FL_RESET        = 8'h00;
  localparam int         MIRROR_UNIT     = 40;
  localparam logic [10:0] MIRROR_UNIT_W  = 11'h028;
  localparam int         CLK_MHZ         = 40;
  localparam int         PUMP_FREQ_KHZ   = 1300;
  localparam int         PUMP_HALF_CYC   = (CLK_MHZ * 1000) / (2 * PUMP_FREQ_KHZ);
  localparam logic [1:0] BYTE_ADDR       = 2'h0;
  localparam logic [1:0] BYTE_SEL        = 2'h1;
  localparam logic [1:0] BYTE_VAL        = 2'h2;
  localparam logic [1:0] BYTE_DONE       = 2'h3;
  typedef enum logic [1:0] {
    PH_CHARGE   = 2'b01,
    PH_TRANSFER = 2'b10
  } pump_phase_t;
endpackage

// ### core/bit_sync.sv
module bit_sync (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic din,
  output logic      dout
);
  logic meta_ff;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      meta_ff <= 1'b0;
      dout    <= 1'b0;
    end else begin
      meta_ff <= din;
      dout    <= meta_ff;
    end
  end
endmodule // bit_sync

// ### test/i2c_host_model.sv
module i2c_host_model (
  output logic     scl,
  output logic     sda_lo,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  int acks;
  initial begin
    scl = 1'b1;
    sda_lo = 1'b0;
  end
  task automatic send(input logic [23:0] f, input int n);
    sda_lo = 1'b1;
    #6 scl = 1'b0;
    for (int i = 0; i < n * 9; i++) begin
      #3 sda_lo = (i % 9 == 8) ? 1'b0 : !f[23 - i + i / 9];
      #3 scl = 1'b1;
      if (i % 9 == 8 && !sda) acks++;
      #6 scl = 1'b0;
    end
    #3 sda_lo = 1'b1;
    #3 scl = 1'b1;
    #6 sda_lo = 1'b0;
  endtask
endmodule // i2c_host_model

// ### test/led_current_i2c_slave_chk.sv
module led_current_i2c_slave_chk (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        overvoltage_monitor,
  input wire logic [7:0]  backlight_current_level,
  input wire logic [7:0]  flash_current_level,
  input wire logic        fourth_led_connect,
  input wire logic [10:0] backlight_mirror_gain,
  input wire logic [10:0] flash_mirror_gain,
  input wire logic        pump_enable,
  input wire logic        pump_charge,
  input wire logic        pump_transfer
);
  wire logic [7:0] bk = backlight_current_level;
  wire logic [7:0] fl = flash_current_level;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  sequence s_chg_end;
    $fell(pump_charge) && pump_enable && !overvoltage_monitor;
  endsequence
  property p_bk_gain; backlight_mirror_gain == 11'(40 * $past(bk[4:0])); endproperty
  property p_fl_gain; flash_mirror_gain == 11'(40 * $past(fl[6:0])); endproperty
  property p_pump_on; pump_enable == ($past(bk[4:0]) != 0 || $past(fl[6:0]) != 0); endproperty
  property p_led4; $stable(bk) [*2] |-> fourth_led_connect == bk[7]; endproperty
  property p_ovp; overvoltage_monitor [*5] |-> !pump_charge && !pump_transfer; endproperty
  property p_phase; s_chg_end |-> ##[0:1] pump_transfer; endproperty
  property p_off; !pump_enable [*3] |-> !pump_charge && !pump_transfer; endproperty
  property p_rst; $rose(rstn) |-> bk == 8'h00 && fl == 8'h00; endproperty
  a_bk_gain: assert property (p_bk_gain) else $error("bk gain");
  a_fl_gain: assert property (p_fl_gain) else $error("fl gain");
  a_pump_on: assert property (p_pump_on) else $error("pump enable");
  a_led4: assert property (p_led4) else $error("led4");
  a_ovp: assert property (p_ovp) else $error("ovp halt");
  a_phase: assert property (p_phase) else $error("phase order");
  a_off: assert property (p_off) else $error("pump off");
  a_rst: assert property (p_rst) else $error("reset value");
endmodule // led_current_i2c_slave_chk

// ### test/led_current_i2c_slave_tb_top.sv
module led_current_i2c_slave_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic        overvoltage_monitor = 1'b0;
  logic [7:0]  backlight_current_level, flash_current_level, s, v;
  logic [10:0] backlight_mirror_gain, flash_mirror_gain;
  logic        scl, sda_lo, sda_in, sda_out, sda_oe, fourth_led_connect, pump_enable, pump_charge, pump_transfer;
  int          fail_count, num_checks, bk_m, fl_m, a0;
  always #12.5 mclk = ~mclk;
  assign sda_in = !(sda_lo || sda_oe && !sda_out);
  i2c_host_model i_host (.scl, .sda_lo, .sda(sda_in));
  led_current_i2c_slave i_dut (.mclk, .rstn, .scl, .sda_in, .sda_out, .sda_oe, .overvoltage_monitor,
    .backlight_current_level, .flash_current_level, .fourth_led_connect, .backlight_mirror_gain,
    .flash_mirror_gain, .pump_enable, .pump_charge, .pump_transfer);
  task automatic chk(input string nm, input logic [10:0] e, g);
    num_checks++;
    fail_count += (g !== e);
    if (g !== e) $display("wrong value %s expected %0h seen %0h", nm, e, g);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic frame(input logic [7:0] a, sel, val, input int n);
    @(posedge mclk);
    #2 overvoltage_monitor = 1'($urandom);
    a0 = i_host.acks;
    i_host.send({a, sel, val}, n);
    repeat (12) @(posedge mclk);
    #2;
    if (a == 8'h72 && n == 3 && sel == 8'h01) bk_m = val;
    if (a == 8'h72 && n == 3 && sel == 8'h02) fl_m = val;
    chk("ack", 11'(a == 8'h72 ? n : 0), 11'(i_host.acks - a0));
    chk("bk gain", 11'(40 * (bk_m % 32)), backlight_mirror_gain);
    chk("led4", 11'((bk_m >> 7) & 1), 11'(fourth_led_connect));
    chk("backlight", 11'(bk_m), 11'(backlight_current_level));
    chk("flash", 11'(fl_m), 11'(flash_current_level));
    chk("pump", 11'(bk_m % 32 + fl_m % 128 != 0), 11'(pump_enable));
  endtask
  initial begin
    #60us;
    fail_count++;
    complete_run;
  end
  initial begin
    void'($urandom(62));
    #1;
    fork
      i_host.send(24'h000000, 1);
    join_none
    repeat (12) @(posedge mclk);
    #2 rstn = 1'b1;
    i_host.send(24'h000000, 1);
    frame(8'h74, 8'h01, 8'h9F, 3);
    for (int i = 0; i < 20; i++) begin
      s = 8'($urandom_range(1, 2));
      v = 8'($urandom);
      if (s == 8'h01) v[6:5] = 2'b00;
      else v[7] = 1'b0;
      frame(8'h72, s, v, 3);
    end
    frame(8'h72, 8'h03, 8'h55, 3);
    frame(8'h72, 8'h01, 8'h1F, 2);
    frame(8'h72, 8'h01, 8'h00, 3);
    frame(8'h72, 8'h02, 8'h00, 3);
    complete_run;
  end
endmodule // led_current_i2c_slave_tb_top
bind led_current_i2c_slave led_current_i2c_slave_chk i_chk (.mclk, .rstn, .overvoltage_monitor,
  .backlight_current_level, .flash_current_level, .fourth_led_connect, .backlight_mirror_gain,
  .flash_mirror_gain, .pump_enable, .pump_charge, .pump_transfer);
